// ==== include/dsc_defines.svh ====
// Constants of the DTMF serial control and detect block
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// ****************************************************************
// Clock rates and derived counts
// ****************************************************************
`define DSC_PCLK_HZ       50000000
`define DSC_XTAL_HZ       3579545
`define DSC_XTAL_PER_MS   ((`DSC_XTAL_HZ + 999) / 1000)
`define DSC_TD_PULSE_NS   1000
`define DSC_TD_PULSE_CYC  \
  ((`DSC_TD_PULSE_NS * (`DSC_PCLK_HZ / 1000000) + 999) / 1000)

// ****************************************************************
// Guard intervals in ms, per guard_time_sel code
// ****************************************************************
`define DSC_ON_MS_01      6'd20
`define DSC_ON_MS_10      6'd30
`define DSC_ON_MS_11      6'd40
`define DSC_OFF_MS_01     6'd20
`define DSC_OFF_MS_10     6'd30
`define DSC_OFF_MS_11     6'd20

// ****************************************************************
// Serial words and control field positions
// ****************************************************************
`define DSC_CTRL_BITS     14
`define DSC_STAT_BITS     4
`define DSC_MODE_LSB      11
`define DSC_SQ_BIT        10
`define DSC_GUARD_LSB     8
`define DSC_LEVEL_LSB     4
`define DSC_TONE_LSB      0
`define DSC_CTRL_RESET    14'h2000

// ****************************************************************
// APB register offsets and interrupt bits
// ****************************************************************
`define DSC_OFS_CONTROL   8'h00
`define DSC_OFS_STATUS    8'h04
`define DSC_OFS_IRQ_STAT  8'h08
`define DSC_OFS_IRQ_MASK  8'h0C
`define DSC_OFS_SHIFT     8'h10
`define DSC_IRQ_BITS      4
`define DSC_IRQ_DV_ON     0
`define DSC_IRQ_DV_OFF    1
`define DSC_IRQ_CTRL      2
`define DSC_IRQ_CHANGE    3

`endif

// ==== include/dsc_pkg.sv ====
// Types shared by the DTMF serial control and detect block
package dsc_pkg;

  // Function modes carried by the mode control word
  typedef enum logic [2:0] {
    DSC_MODE_RX       = 3'b000,
    DSC_MODE_TX       = 3'b001,
    DSC_MODE_SINGLE   = 3'b010,
    DSC_MODE_PD1      = 3'b011,
    DSC_MODE_PD2      = 3'b100,
    DSC_MODE_LOOPBACK = 3'b101
  } dsc_mode_t;

  typedef logic [1:0] dsc_guard_t;
  typedef logic [5:0] dsc_ms_t;

endpackage : dsc_pkg

// ==== include/dsc_guard_if.sv ====
// Carrier between the main block and its guard timer
interface dsc_guard_if;
  import dsc_pkg::*;
  logic    tone_on;
  logic    ms_tick;
  dsc_ms_t on_ms;
  dsc_ms_t off_ms;
  logic    valid;

  modport timer (input tone_on, ms_tick, on_ms, off_ms, output valid);
  modport ctrl  (output tone_on, ms_tick, on_ms, off_ms, input valid);
endinterface : dsc_guard_if

// ==== logic/dsc_xtal_tick.sv ====
// Crystal rate emulation and millisecond tick for guard timing
`include "dsc_defines.svh"
module dsc_xtal_tick #(
  parameter int PCLK_HZ   = `DSC_PCLK_HZ,
  parameter int XTAL_HZ   = `DSC_XTAL_HZ,
  parameter int XTAL_PER_MS = `DSC_XTAL_PER_MS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      xtal_tick,
  output logic      ms_tick
);
  localparam logic [26:0] STEP = 27'(XTAL_HZ);
  localparam logic [26:0] WRAP = 27'(PCLK_HZ);
  localparam logic [11:0] LAST = 12'(XTAL_PER_MS - 1);

  logic [26:0] acc;
  logic [11:0] xcnt;
  wire  [26:0] acc_sum = acc + STEP;
  wire         acc_wrap = (acc_sum >= WRAP);

  // Fractional divider: one pulse per crystal period on average
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc       <= 27'h0000000;
      xtal_tick <= 1'b0;
    end else begin
      acc       <= acc_wrap ? acc_sum - WRAP : acc_sum;
      xtal_tick <= acc_wrap;
    end
  end

  // Crystal periods counted into whole milliseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcnt    <= 12'h000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      if (xtal_tick) begin
        xcnt    <= (xcnt == LAST) ? 12'h000 : xcnt + 12'h001;
        ms_tick <= (xcnt == LAST);
      end
    end
  end
endmodule : dsc_xtal_tick

// ==== logic/dsc_guard_timer.sv ====
// Guard interval filter producing the data valid level
module dsc_guard_timer (
  input  wire logic   pclk,
  input  wire logic   presetn,
  dsc_guard_if.timer  gi
);
  import dsc_pkg::*;

  dsc_ms_t cnt;
  wire dsc_ms_t target = gi.tone_on ? gi.on_ms : gi.off_ms;
  wire          done   = (cnt + 6'h01 >= target);

  // Level flips only after input held opposite for the whole interval;
  // a dropout shorter than the interval restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 6'h00;
      gi.valid <= 1'b0;
    end else if (gi.tone_on == gi.valid) begin
      cnt <= 6'h00;
    end else if (gi.ms_tick) begin
      cnt      <= done ? 6'h00 : cnt + 6'h01;
      gi.valid <= done ? gi.tone_on : gi.valid;
    end
  end
endmodule : dsc_guard_timer

// ==== logic/dsc_top.sv ====
// DTMF serial control port, detect sequencing and APB register file
`include "dsc_defines.svh"
module dsc_top #(
  parameter int XTAL_PER_MS  = `DSC_XTAL_PER_MS,
  parameter int TD_PULSE_CYC = `DSC_TD_PULSE_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              serial_clk,
  input  wire logic              transfer_strobe,
  input  wire logic              direction_select,
  input  wire logic              data_in,
  output logic                   data_out,
  output logic                   data_oe,
  input  wire logic              tone_present,
  input  wire logic [3:0]        tone_digit,
  output logic                   tone_detect_n,
  output logic                   data_valid_n,
  output dsc_pkg::dsc_mode_t     function_mode_sel,
  output logic                   tx_squelch,
  output dsc_pkg::dsc_guard_t    guard_time_sel,
  output logic [3:0]             tx_level_code,
  output logic [3:0]             tx_tone_code,
  output logic [3:0]             tx_atten_db,
  output logic                   rx_enable,
  output logic                   tx_enable,
  output logic                   single_tone_enable,
  output logic                   power_down_1,
  output logic                   power_down_2,
  output logic                   analog_loopback
);
  import dsc_pkg::*;

  localparam int CW = `DSC_CTRL_BITS;
  localparam int SW = `DSC_STAT_BITS;
  localparam int IW = `DSC_IRQ_BITS;
  localparam logic [7:0] PULSE_LAST = 8'(TD_PULSE_CYC - 1);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Attenuation in dB equals the level code, one dB per step
  function automatic logic [3:0] dsc_atten(input logic [3:0] code);
    dsc_atten = code;
  endfunction : dsc_atten

  // Detect-on guard interval in ms; reserved 00 is handled as 01
  function automatic dsc_ms_t dsc_on_ms(input dsc_guard_t sel);
    dsc_on_ms = (sel == 2'h3) ? `DSC_ON_MS_11 :
                (sel == 2'h2) ? `DSC_ON_MS_10 : `DSC_ON_MS_01;
  endfunction : dsc_on_ms

  // Release guard interval in ms
  function automatic dsc_ms_t dsc_off_ms(input dsc_guard_t sel);
    dsc_off_ms = (sel == 2'h3) ? `DSC_OFF_MS_11 :
                 (sel == 2'h2) ? `DSC_OFF_MS_10 : `DSC_OFF_MS_01;
  endfunction : dsc_off_ms

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_c;

  // Two stages before use; third stage only for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      sync_c <= 4'h0;
    end else begin
      sync_a <= {serial_clk, transfer_strobe, direction_select, data_in};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  wire sclk_rise   = sync_b[3] & ~sync_c[3];
  wire strobe_now  = sync_b[2];
  wire strobe_rise = sync_b[2] & ~sync_c[2];
  wire dir_read    = sync_b[1];
  wire din_now     = sync_b[0];
  wire wr_shift    = ~dir_read & sclk_rise;
  wire rd_load     = dir_read & strobe_rise;
  wire rd_shift    = dir_read & sclk_rise;

  // ****************************************************************
  // Control word path
  // ****************************************************************
  logic [CW-1:0] shift_word;
  logic [CW-1:0] ctrl_word;

  // first bit in ends up in the top of the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_word <= '0;
    end else if (wr_shift) begin
      shift_word <= {shift_word[CW-2:0], din_now};
    end
  end

  // strobe high transfers the word straight to mode control
  // relies on host not toggling direction under a high strobe
  // reset value selects the deepest power down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_word <= `DSC_CTRL_RESET;
    end else if (strobe_now && !dir_read) begin
      ctrl_word <= shift_word;
    end
  end

  wire ctrl_load = strobe_rise & ~dir_read;

  // Field split of the applied word
  wire dsc_mode_t  mode_w  = dsc_mode_t'(ctrl_word[`DSC_MODE_LSB +: 3]);
  wire             sq_w    = ctrl_word[`DSC_SQ_BIT];
  wire dsc_guard_t guard_w = ctrl_word[`DSC_GUARD_LSB +: 2];
  wire [3:0]       level_w = ctrl_word[`DSC_LEVEL_LSB +: 4];
  wire [3:0]       tone_w  = ctrl_word[`DSC_TONE_LSB +: 4];

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic [5:0] next_mode_en;

  // one enable per function; unused codes enable nothing
  always_comb begin
    next_mode_en = 6'h00;
    case (mode_w)
      DSC_MODE_RX:       next_mode_en = 6'h01;
      DSC_MODE_TX:       next_mode_en = 6'h02;
      DSC_MODE_SINGLE:   next_mode_en = 6'h04;
      DSC_MODE_PD1:      next_mode_en = 6'h08;
      DSC_MODE_PD2:      next_mode_en = 6'h10;
      DSC_MODE_LOOPBACK: next_mode_en = 6'h20;
      default:           next_mode_en = 6'h00;
    endcase
  end

  // Registered control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_mode_sel  <= DSC_MODE_PD2;
      tx_squelch         <= 1'b0;
      guard_time_sel     <= 2'h0;
      tx_level_code      <= 4'h0;
      tx_tone_code       <= 4'h0;
      tx_atten_db        <= 4'h0;
      {analog_loopback, power_down_2, power_down_1,
       single_tone_enable, tx_enable, rx_enable} <= 6'h10;
    end else begin
      function_mode_sel  <= mode_w;
      tx_squelch         <= sq_w;
      guard_time_sel     <= guard_w;
      tx_level_code      <= level_w;
      tx_tone_code       <= tone_w;
      tx_atten_db        <= dsc_atten(level_w);
      {analog_loopback, power_down_2, power_down_1,
       single_tone_enable, tx_enable, rx_enable} <= next_mode_en;
    end
  end

  // Receiver listens in receive and loopback only
  wire rx_active = (mode_w == DSC_MODE_RX) ||
                   (mode_w == DSC_MODE_LOOPBACK);
  wire tone_on   = tone_present & rx_active;

  // ****************************************************************
  // Tone detect sequencing
  // ****************************************************************
  logic       tone_on_q;
  logic [3:0] prev_digit;
  logic [3:0] digit_held;
  logic [7:0] pulse_cnt;
  logic       pulse_act;

  wire digit_change = tone_on & tone_on_q & (tone_digit != prev_digit);

  // every one of the sixteen codes is held as reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_on_q  <= 1'b0;
      prev_digit <= 4'h0;
      digit_held <= 4'h0;
    end else begin
      tone_on_q <= tone_on;
      if (tone_on) begin
        prev_digit <= tone_digit;
        digit_held <= tone_digit;
      end
    end
  end

  // short high pulse marks a change without silence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= 8'h00;
      pulse_act <= 1'b0;
    end else if (digit_change) begin
      pulse_cnt <= PULSE_LAST;
      pulse_act <= 1'b1;
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end else begin
      pulse_act <= 1'b0;
    end
  end

  // no guard on this output, only one register delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_detect_n <= 1'b1;
    end else begin
      tone_detect_n <= ~tone_on | digit_change | pulse_act;
    end
  end

  // ****************************************************************
  // Guard timing
  // ****************************************************************
  dsc_guard_if gi ();
  logic        ms_tick;
  logic        dv_q;

  // millisecond base derived from emulated crystal ticks
  dsc_xtal_tick #(
    .PCLK_HZ     (`DSC_PCLK_HZ),
    .XTAL_HZ     (`DSC_XTAL_HZ),
    .XTAL_PER_MS (XTAL_PER_MS)
  ) u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .xtal_tick (),
    .ms_tick   (ms_tick)
  );

  // interval pair picked by the guard code
  assign gi.tone_on = tone_on;
  assign gi.ms_tick = ms_tick;
  assign gi.on_ms   = dsc_on_ms(guard_w);
  assign gi.off_ms  = dsc_off_ms(guard_w);

  // both edges of data valid wait out their interval
  dsc_guard_timer u_guard (
    .pclk    (pclk),
    .presetn (presetn),
    .gi      (gi.timer)
  );

  assign data_valid_n = ~gi.valid;

  // Previous valid level for event edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_q <= 1'b0;
    end else begin
      dv_q <= gi.valid;
    end
  end

  // ****************************************************************
  // Status read path
  // ****************************************************************
  logic [SW-1:0] stat_word;
  logic          stat_valid;

  // strobe loads the digit held before it; D0 first
  // each clock rise rotates, so the first gives D1
  // rotation repeats the same capture until the next strobe
  // leaving read clears and releases the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_word  <= '0;
      stat_valid <= 1'b0;
    end else if (!dir_read) begin
      stat_word  <= '0;
      stat_valid <= 1'b0;
    end else if (rd_load) begin
      stat_word  <= digit_held;
      stat_valid <= 1'b1;
    end else if (rd_shift && stat_valid) begin
      stat_word  <= {stat_word[0], stat_word[SW-1:1]};
    end
  end

  // clock edges under a high strobe are not expected
  assign data_out = stat_word[0];
  assign data_oe  = stat_valid & dir_read;

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [IW-1:0] irq_stat;
  logic [IW-1:0] irq_mask;
  wire  [IW-1:0] irq_set;

  assign irq_set[`DSC_IRQ_DV_ON]  = gi.valid & ~dv_q;
  assign irq_set[`DSC_IRQ_DV_OFF] = ~gi.valid & dv_q;
  assign irq_set[`DSC_IRQ_CTRL]   = ctrl_load;
  assign irq_set[`DSC_IRQ_CHANGE] = digit_change;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_ctrl   = (paddr == `DSC_OFS_CONTROL);
  wire hit_stat   = (paddr == `DSC_OFS_STATUS);
  wire hit_istat  = (paddr == `DSC_OFS_IRQ_STAT);
  wire hit_imask  = (paddr == `DSC_OFS_IRQ_MASK);
  wire hit_shift  = (paddr == `DSC_OFS_SHIFT);
  wire hit_any    = hit_ctrl | hit_stat | hit_istat | hit_imask |
                    hit_shift;
  wire wr_ok      = apb_access & pwrite & pstrb[0];
  wire [IW-1:0] irq_clr = (wr_ok && hit_istat) ? pwdata[IW-1:0] : '0;

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    hit_ctrl  ? {18'h00000, ctrl_word} :
    hit_stat  ? {24'h000000, dir_read, stat_valid, gi.valid,
                 ~tone_detect_n, digit_held} :
    hit_istat ? {28'h0000000, irq_stat} :
    hit_imask ? {28'h0000000, irq_mask} :
    hit_shift ? {18'h00000, shift_word} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~hit_any;
  assign irq     = |(irq_stat & irq_mask);

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Sticky bits: a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_ok && hit_imask) begin
        irq_mask <= pwdata[IW-1:0];
      end
    end
  end
endmodule : dsc_top

// ==== verification/dsc_chk.sv ====
// Port level checks of the detect sequencing and serial control block
module dsc_chk #(
  parameter int XTAL_PER_MS = 4
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pslverr,
  input wire logic               direction_select,
  input wire logic               data_oe,
  input wire logic               tone_present,
  input wire logic [3:0]         tone_digit,
  input wire logic               tone_detect_n,
  input wire logic               data_valid_n,
  input wire dsc_pkg::dsc_mode_t function_mode_sel,
  input wire logic [3:0]         tx_level_code,
  input wire logic [3:0]         tx_atten_db,
  input wire logic               rx_enable,
  input wire logic               tx_enable,
  input wire logic               power_down_2,
  input wire logic               analog_loopback
);
  import dsc_pkg::*;
  // Shortest guard allowed: 20 ms less one ms tick, pclk counted low
  localparam int MIN_GUARD = 19 * XTAL_PER_MS * 13;
  logic [15:0] on_cnt;
  logic [15:0] off_cnt;
  wire logic   is_rx = function_mode_sel == DSC_MODE_RX;

  // Run lengths of tone presence and absence, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt  <= '0;
      off_cnt <= '0;
    end else begin
      on_cnt  <= !tone_present ? '0 : on_cnt + 16'(on_cnt != '1);
      off_cnt <= tone_present ? '0 : off_cnt + 16'(off_cnt != '1);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_td_follow: assert property (
    is_rx && $stable(function_mode_sel) && !tone_present |=> tone_detect_n)
    else $error("tone detect not released");
  a_td_change: assert property (
    is_rx && tone_present && $past(tone_present)
    && tone_digit != $past(tone_digit) |-> ##1 tone_detect_n)
    else $error("no pulse on digit change");
  a_dv_on_guard: assert property (
    $fell(data_valid_n) |-> on_cnt >= MIN_GUARD)
    else $error("data valid set before guard");
  a_dv_off_guard: assert property (
    $rose(data_valid_n) |-> off_cnt >= MIN_GUARD)
    else $error("data valid released early");
  a_oe_release: assert property (
    $fell(direction_select) |-> ##[1:6] !data_oe)
    else $error("data pin still driven");
  a_reset_mode: assert property (
    $rose(presetn) |-> function_mode_sel == DSC_MODE_PD2 && power_down_2)
    else $error("reset mode wrong");
  a_mode_decode: assert property (
    $stable(function_mode_sel) |->
    rx_enable == is_rx && tx_enable == (function_mode_sel == DSC_MODE_TX)
    && power_down_2 == (function_mode_sel == DSC_MODE_PD2)
    && analog_loopback == (function_mode_sel == DSC_MODE_LOOPBACK))
    else $error("mode decode wrong");
  a_atten_copy: assert property (
    $stable(tx_level_code) |-> tx_atten_db == tx_level_code)
    else $error("attenuation differs from level");
  a_err_access: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access");
endmodule : dsc_chk

// ==== verification/dsc_host_model.sv ====
// Host CPU model driving the serial control pins
module dsc_host_model (
  input  wire logic pclk,
  input  wire logic data_out,
  output logic      serial_clk,
  output logic      transfer_strobe,
  output logic      direction_select,
  output logic      data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles per pin level; 4 gives the 160 ns link clock
  int half = 4;

  // Pins start idle
  initial begin
    serial_clk       = 1'b0;
    transfer_strobe  = 1'b0;
    direction_select = 1'b0;
    data_in          = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  task automatic set_dir(input logic d);
    wt(1);
    direction_select <= d;
    wt(half);
  endtask : set_dir

  task automatic write_word(input logic [13:0] w);
    set_dir(1'b0);
    for (int i = 13; i >= 0; i--) begin
      data_in <= w[i];
      wt(half);
      serial_clk <= 1'b1;
      wt(half);
      serial_clk <= 1'b0;
    end
    // Released line shows no stale level
    data_in <= ~w[0];
    wt(half);
    transfer_strobe <= 1'b1;
    wt(2 * half);
    transfer_strobe <= 1'b0;
    wt(half);
  endtask : write_word

  task automatic read_bits(input int n, output logic [7:0] b);
    b = '0;
    set_dir(1'b1);
    transfer_strobe <= 1'b1;
    wt(half);
    transfer_strobe <= 1'b0;
    wt(2 * half);
    b[0] = data_out;
    for (int k = 1; k < n; k++) begin
      serial_clk <= 1'b1;
      wt(half);
      serial_clk <= 1'b0;
      wt(half);
      b[k] = data_out;
    end
  endtask : read_bits
endmodule : dsc_host_model

// ==== verification/dsc_top_tb_top.sv ====
// Self-checking bench of the detect and serial control block
`include "dsc_defines.svh"
module dsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic        tone_present = 1'b0;
  logic [3:0]  tone_digit = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err, data_out, data_oe;
  logic        serial_clk, transfer_strobe, direction_select, data_in;
  logic        tone_detect_n, data_valid_n, tx_squelch;
  logic        rx_enable, tx_enable, single_tone_enable;
  logic        power_down_1, power_down_2, analog_loopback;
  logic [3:0]  tx_level_code, tx_tone_code, tx_atten_db;
  dsc_mode_t   function_mode_sel;
  dsc_guard_t  guard_time_sel;
  int          fail_count = 0;
  int          num_checks = 0;

  // Short ms and pulse counts keep the run brief
  dsc_top #(.XTAL_PER_MS(4), .TD_PULSE_CYC(4)) dut (.*);

  dsc_host_model host (.*);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      $display("Error %0t: %s", $time, msg);
      fail_count++;
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    pstrb  <= {4{w}};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk(1'b0, "bus hang");
      final_report();
    end
  endtask : apb

  // Cycles until data valid reaches lvl, against ms at 4 ticks per ms
  task automatic dv_time(input logic lvl, input int ms);
    int  n;
    real exp;
    n = 2;
    exp = ms * 4.0 * 50.0e6 / 3579545.0;
    while (data_valid_n !== lvl && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk(n > exp - 70 && n < exp + 70, "guard length wrong");
    if (n >= 4000) final_report();
  endtask : dv_time

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(function_mode_sel === DSC_MODE_PD2 && power_down_2 === 1'b1, "pd");
    chk(tone_detect_n === 1'b1 && data_valid_n === 1'b1, "idle pins");
    apb(1'b0, `DSC_OFS_CONTROL, 32'h0);
    chk(rd === 32'h0000_2000, "reset word");
    apb(1'b0, 8'h20, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_modes;
    logic [13:0] w;
    for (int m = 0; m < 6; m++) begin
      w = {3'(m), 1'(m & 1), 2'b01, 4'(m * 3), 4'(15 - m)};
      host.write_word(w);
      wt(2);
      chk(function_mode_sel === dsc_mode_t'(3'(m)), "mode");
      chk({analog_loopback, power_down_2, power_down_1, single_tone_enable,
           tx_enable, rx_enable} === 6'(1 << m), "decode");
      chk(tx_atten_db === 4'(m * 3), "attenuation");
      chk(tx_tone_code === 4'(15 - m) && tx_squelch === 1'(m & 1), "f");
      chk(guard_time_sel === 2'b01, "guard code");
      apb(1'b0, `DSC_OFS_CONTROL, 32'h0);
      chk(rd === {18'h0, w}, "control word");
      apb(1'b0, `DSC_OFS_SHIFT, 32'h0);
      chk(rd === {18'h0, w}, "shift word");
    end
  endtask : t_modes

  task automatic t_guard;
    int on_ms[3] = '{20, 30, 40};
    int off_ms[3] = '{20, 30, 20};
    apb(1'b1, `DSC_OFS_IRQ_MASK, 32'h1);
    for (int g = 1; g <= 3; g++) begin
      host.write_word({3'b000, 1'b0, 2'(g), 8'h00});
      apb(1'b1, `DSC_OFS_IRQ_STAT, 32'hF);
      tone_present <= 1'b1;
      tone_digit   <= 4'(g);
      wt(2);
      chk(tone_detect_n === 1'b0 && data_valid_n === 1'b1, "detect");
      dv_time(1'b0, on_ms[g - 1]);
      wt(3);
      chk(irq === 1'b1, "irq on");
      apb(1'b1, `DSC_OFS_IRQ_MASK, 32'h0);
      wt(1);
      chk(irq === 1'b0, "irq masked");
      apb(1'b1, `DSC_OFS_IRQ_MASK, 32'h1);
      apb(1'b1, `DSC_OFS_IRQ_STAT, 32'h1);
      wt(1);
      chk(irq === 1'b0, "irq cleared");
      tone_present <= 1'b0;
      wt(2);
      chk(tone_detect_n === 1'b1, "tone gone");
      dv_time(1'b1, off_ms[g - 1]);
    end
  endtask : t_guard

  task automatic t_read;
    logic [7:0] b;
    host.write_word(14'h0100);
    tone_present <= 1'b1;
    // Gapless digit walk, host speed varied
    for (int d = 0; d < 16; d++) begin
      tone_digit <= 4'(d);
      host.half = 4 + d % 3;
      wt(3);
      host.read_bits(4, b);
      chk(b[3:0] === 4'(d) && data_oe === 1'b1, "digit");
      host.set_dir(1'b0);
      wt(2);
      chk(data_oe === 1'b0 && data_out === 1'b0, "released");
    end
    host.half = 4;
    fork
      host.read_bits(8, b);
      begin
        wt(14);
        tone_digit <= 4'hA;
        wt(2);
        chk(tone_detect_n === 1'b1, "change pulse");
      end
    join
    chk(b === 8'hFF, "capture held");
    host.set_dir(1'b0);
    apb(1'b0, `DSC_OFS_STATUS, 32'h0);
    chk(rd[3:0] === 4'hA, "status digit");
    host.read_bits(4, b);
    chk(b[3:0] === 4'hA, "reload");
    host.set_dir(1'b0);
    tone_present <= 1'b0;
  endtask : t_read

  // Clock and main sequence
  always #10 pclk = ~pclk;
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wt(4);
    t_reset();
    t_modes();
    t_guard();
    t_read();
    final_report();
  end
endmodule : dsc_top_tb_top

bind dsc_top dsc_chk #(.XTAL_PER_MS(XTAL_PER_MS)) u_chk (.*);
